// ==== src/ext_irq_pkg.sv ====
// Shared constants, field layouts and carrier types of the external interrupt pair control
package ext_irq_pkg;

    localparam int          DATA_W         = 32;
    localparam int          MIN_ADR_W      = 10;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0]  IDX_CONTROL    = 8'hC0;
    localparam logic [7:0]  IDX_PRIO_HIGH  = 8'hC1;
    localparam logic [7:0]  IDX_GATE       = 8'hD0;
    localparam logic [7:0]  IDX_STATUS     = 8'hD1;
    localparam logic [7:0]  IDX_MASK       = 8'hD2;
    localparam logic [7:0]  IDX_CORE_STATE = 8'hD3;

    // Control register fields
    localparam int          CTL_C_PRIO_LOW = 7;
    localparam int          CTL_C_ENABLE   = 6;
    localparam int          CTL_C_FLAG     = 5;
    localparam int          CTL_C_TRIG     = 4;
    localparam int          CTL_B_PRIO_LOW = 3;
    localparam int          CTL_B_ENABLE   = 2;
    localparam int          CTL_B_FLAG     = 1;
    localparam int          CTL_B_TRIG     = 0;

    // Priority-high register fields
    localparam int          PH_C_HIGH      = 7;
    localparam int          PH_B_HIGH      = 3;

    // Gate, status and mask fields
    localparam int          GATE_BIT       = 0;
    localparam int          EVT_B          = 0;
    localparam int          EVT_C          = 1;

    // Core-state readback fields
    localparam int          CS_VALID       = 0;
    localparam int          CS_SEL         = 1;
    localparam int          CS_LEVEL_LO    = 2;

    localparam logic [1:0]  EVT_RST        = 2'h0;
    localparam logic        GATE_RST       = 1'b0;
    localparam logic        PIN_IDLE       = 1'b1;
    localparam logic        SRC_B          = 1'b0;
    localparam logic        SRC_C          = 1'b1;

    typedef struct packed {
        logic       trig_edge;
        logic       enable;
        logic       prio_low;
        logic       prio_high;
    } irq_cfg_t;

    localparam irq_cfg_t    CFG_RST        = '{1'b0, 1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic       valid;
        logic       sel;
        logic [1:0] level;
    } core_req_t;

    localparam core_req_t   CORE_REQ_RST   = '{1'b0, 1'b0, 2'h0};

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } bus_state_t;

endpackage

// ==== src/irq_pin_detect.sv ====
// Pin synchroniser with agreement filter and falling-edge or low-level request detection
`timescale 1ns/1ns
module irq_pin_detect (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic pin,
    input  wire logic trig_edge,
    output logic      detect
);

    logic [2:0] sync_r;
    logic [2:0] sync_nxt;
    logic       lvl_r;
    logic       lvl_nxt;
    logic       det_r;
    logic       det_nxt;

    always_comb begin
        sync_nxt = {sync_r[1:0], pin};
        // A change counts only once the second and third stages agree
        lvl_nxt  = (sync_r[1] == sync_r[2]) ? sync_r[2] : lvl_r;
        if (trig_edge) begin
            det_nxt = lvl_r & ~lvl_nxt; // R1 R2
        end else begin
            det_nxt = ~lvl_nxt; // R1 R2
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync_r <= {3{ext_irq_pkg::PIN_IDLE}};
            lvl_r  <= ext_irq_pkg::PIN_IDLE;
            det_r  <= 1'b0;
        end else begin
            sync_r <= sync_nxt;
            lvl_r  <= lvl_nxt;
            det_r  <= det_nxt;
        end
    end

    assign detect = det_r;

endmodule // irq_pin_detect

// ==== src/irq_prio_arbiter.sv ====
// Picks the pending enabled request with the greater two-bit level
`timescale 1ns/1ns
module irq_prio_arbiter (
    input  wire logic                   pend_b,
    input  wire logic                   pend_c,
    input  wire ext_irq_pkg::irq_cfg_t  cfg_b,
    input  wire ext_irq_pkg::irq_cfg_t  cfg_c,
    output ext_irq_pkg::core_req_t      winner
);

    logic [1:0] lvl_b;
    logic [1:0] lvl_c;

    always_comb begin
        lvl_b  = {cfg_b.prio_high, cfg_b.prio_low}; // R8 R10 R12
        lvl_c  = {cfg_c.prio_high, cfg_c.prio_low}; // R7 R9 R12
        winner = ext_irq_pkg::CORE_REQ_RST;
        // On equal levels the second input is served before the third
        if (pend_b && (!pend_c || lvl_b >= lvl_c)) begin
            winner = '{1'b1, ext_irq_pkg::SRC_B, lvl_b}; // R12
        end else if (pend_c) begin
            winner = '{1'b1, ext_irq_pkg::SRC_C, lvl_c}; // R12
        end
    end

endmodule // irq_prio_arbiter

// ==== src/ext_irq_pair_control.sv ====
// Top of the external interrupt pair control with its classic Wishbone register slave
//
// Behaviour
// R1: Third input: trigger select 1 detects falling edge, 0 detects low level.
// R2: Second input: trigger select 1 detects falling edge, 0 detects low level.
// R3: Third input flag set by hardware on detection, cleared by hardware on service.
// R4: Second input flag set by hardware on detection, cleared by hardware on service.
// R5: Third input reaches the core only while its enable bit is 1.
// R6: Second input reaches the core only while its enable bit is 1.
// R7: Third input low priority bit raises its level by one.
// R8: Second input low priority bit raises its level by one.
// R9: Third input high priority bit places it at the highest level; the code raises its level by two, to 2, or to 3 with the low bit.
// R10: Second input high priority bit places it at the highest level; the code raises its level by two, to 2, or to 3 with the low bit.
// R11: No request passes to the core unless the global gate bit is set.
// R12: Levels are {high,low} from 0 to 3; greater pending level served first.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
module ext_irq_pair_control #(
    parameter int ADR_W = 12
) (
    input  wire logic                       sys_clk,
    input  wire logic                       srst,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [ADR_W-1:0]           wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic [31:0]                     wb_dat_o,
    output logic                            wb_ack_o,
    input  wire logic                       ext_irq_b_pin,
    input  wire logic                       ext_irq_c_pin,
    input  wire logic                       core_ack,
    input  wire logic                       core_ack_sel,
    output ext_irq_pkg::core_req_t          core_req,
    output logic                            irq_o
);

    if (ADR_W < ext_irq_pkg::MIN_ADR_W) begin : g_adr_check
        $error("ADR_W too small for the register map");
    end

    // Byte offsets other than 0 decode as unmapped
    function automatic logic reg_hit(input logic [ADR_W-1:0] adr, input logic [7:0] idx);
        reg_hit = (adr[1:0] == 2'h0) && (adr[ADR_W-1:2] == (ADR_W-2)'(idx));
    endfunction

    function automatic logic [1:0] w1c(input logic [1:0] cur,
                                       input logic [1:0] clr,
                                       input logic [1:0] set);
        // Set wins over a clear in the same cycle
        w1c = (cur & ~clr) | set;
    endfunction

    // Bus slave state
    ext_irq_pkg::bus_state_t bus_state_r;
    ext_irq_pkg::bus_state_t bus_state_nxt;
    logic [31:0]             rdata_r;
    logic [31:0]             rdata_nxt;
    logic                    ack_r;
    logic                    ack_nxt;
    logic                    wr_take;
    logic                    rd_take;

    // Configuration and status state
    ext_irq_pkg::irq_cfg_t   cfg_b_r;
    ext_irq_pkg::irq_cfg_t   cfg_b_nxt;
    ext_irq_pkg::irq_cfg_t   cfg_c_r;
    ext_irq_pkg::irq_cfg_t   cfg_c_nxt;

    logic                    gate_r;
    logic                    gate_nxt;
    logic [1:0]              mask_r;
    logic [1:0]              mask_nxt;
    logic [1:0]              status_r;
    logic [1:0]              status_nxt;

    // Request state
    logic                    flag_b_r;
    logic                    flag_b_nxt;
    logic                    flag_c_r;
    logic                    flag_c_nxt;

    ext_irq_pkg::core_req_t  core_req_r;
    ext_irq_pkg::core_req_t  core_req_nxt;
    logic                    irq_r;
    logic                    irq_nxt;

    logic                    det_b;
    logic                    det_c;
    logic                    serve_b;
    logic                    serve_c;

    ext_irq_pkg::core_req_t  winner;
    logic [7:0]              ctl_view;
    logic [7:0]              ph_view;
    logic [1:0]              evt;

    // Filter and detector per pin
    irq_pin_detect u_det_b (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .pin       (ext_irq_b_pin),
        .trig_edge (cfg_b_r.trig_edge),
        .detect    (det_b)
    );

    irq_pin_detect u_det_c (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .pin       (ext_irq_c_pin),
        .trig_edge (cfg_c_r.trig_edge),
        .detect    (det_c)
    );

    // Pending means flagged and enabled
    irq_prio_arbiter u_arb (
        .pend_b (flag_b_r && cfg_b_r.enable), // R6
        .pend_c (flag_c_r && cfg_c_r.enable), // R5
        .cfg_b  (cfg_b_r),
        .cfg_c  (cfg_c_r),
        .winner (winner)
    );

    // ---------------- Bus slave: one wait cycle, then a one-cycle ack
    always_comb begin
        bus_state_nxt = bus_state_r;

        case (bus_state_r)
            ext_irq_pkg::BUS_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    bus_state_nxt = ext_irq_pkg::BUS_ACK;
                end
            end
            ext_irq_pkg::BUS_ACK: begin
                bus_state_nxt = ext_irq_pkg::BUS_IDLE;
            end
            default: begin
                bus_state_nxt = ext_irq_pkg::BUS_IDLE;
            end
        endcase
        // Ack from its own flop
        ack_nxt = (bus_state_nxt == ext_irq_pkg::BUS_ACK);
    end

    // A write lands on the edge at which the master sees ack
    assign wr_take = (bus_state_r == ext_irq_pkg::BUS_ACK) && wb_cyc_i && wb_stb_i
                     && wb_we_i && wb_sel_i[0];

    assign rd_take = (bus_state_r == ext_irq_pkg::BUS_IDLE) && wb_cyc_i && wb_stb_i
                     && !wb_we_i;

    // Readback views
    always_comb begin
        ctl_view = 8'h00;
        ctl_view[ext_irq_pkg::CTL_C_PRIO_LOW] = cfg_c_r.prio_low;
        ctl_view[ext_irq_pkg::CTL_C_ENABLE]   = cfg_c_r.enable;
        ctl_view[ext_irq_pkg::CTL_C_FLAG]     = flag_c_r;
        ctl_view[ext_irq_pkg::CTL_C_TRIG]     = cfg_c_r.trig_edge;
        ctl_view[ext_irq_pkg::CTL_B_PRIO_LOW] = cfg_b_r.prio_low;
        ctl_view[ext_irq_pkg::CTL_B_ENABLE]   = cfg_b_r.enable;
        ctl_view[ext_irq_pkg::CTL_B_FLAG]     = flag_b_r;
        ctl_view[ext_irq_pkg::CTL_B_TRIG]     = cfg_b_r.trig_edge;

        ph_view = 8'h00;
        ph_view[ext_irq_pkg::PH_C_HIGH] = cfg_c_r.prio_high;
        ph_view[ext_irq_pkg::PH_B_HIGH] = cfg_b_r.prio_high;
    end

    always_comb begin
        // Unmapped addresses and writes answer with zero data
        rdata_nxt = 32'h0000_0000;
        if (rd_take) begin
            if (reg_hit(wb_adr_i, ext_irq_pkg::IDX_CONTROL)) begin
                rdata_nxt[7:0] = ctl_view;
            end else if (reg_hit(wb_adr_i, ext_irq_pkg::IDX_PRIO_HIGH)) begin
                rdata_nxt[7:0] = ph_view;
            end else if (reg_hit(wb_adr_i, ext_irq_pkg::IDX_GATE)) begin
                rdata_nxt[ext_irq_pkg::GATE_BIT] = gate_r;
            end else if (reg_hit(wb_adr_i, ext_irq_pkg::IDX_STATUS)) begin
                rdata_nxt[1:0] = status_r;
            end else if (reg_hit(wb_adr_i, ext_irq_pkg::IDX_MASK)) begin
                rdata_nxt[1:0] = mask_r;
            end else if (reg_hit(wb_adr_i, ext_irq_pkg::IDX_CORE_STATE)) begin
                rdata_nxt[ext_irq_pkg::CS_VALID]  = core_req_r.valid;
                rdata_nxt[ext_irq_pkg::CS_SEL]    = core_req_r.sel;
                rdata_nxt[ext_irq_pkg::CS_LEVEL_LO +: 2] = core_req_r.level;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bus_state_r <= ext_irq_pkg::BUS_IDLE;
            ack_r       <= 1'b0;
            rdata_r     <= 32'h0000_0000;
        end else begin
            bus_state_r <= bus_state_nxt;
            ack_r       <= ack_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    // ---------------- Software-written configuration
    always_comb begin
        cfg_b_nxt = cfg_b_r;
        cfg_c_nxt = cfg_c_r;
        gate_nxt  = gate_r;
        mask_nxt  = mask_r;
        if (wr_take && reg_hit(wb_adr_i, ext_irq_pkg::IDX_CONTROL)) begin
            // Flag bits are hardware-owned; writes to them are ignored
            cfg_c_nxt.prio_low  = wb_dat_i[ext_irq_pkg::CTL_C_PRIO_LOW]; // R7
            cfg_c_nxt.enable    = wb_dat_i[ext_irq_pkg::CTL_C_ENABLE]; // R5
            cfg_c_nxt.trig_edge = wb_dat_i[ext_irq_pkg::CTL_C_TRIG]; // R1
            cfg_b_nxt.prio_low  = wb_dat_i[ext_irq_pkg::CTL_B_PRIO_LOW]; // R8
            cfg_b_nxt.enable    = wb_dat_i[ext_irq_pkg::CTL_B_ENABLE]; // R6
            cfg_b_nxt.trig_edge = wb_dat_i[ext_irq_pkg::CTL_B_TRIG]; // R2
        end

        if (wr_take && reg_hit(wb_adr_i, ext_irq_pkg::IDX_PRIO_HIGH)) begin
            cfg_c_nxt.prio_high = wb_dat_i[ext_irq_pkg::PH_C_HIGH]; // R9
            cfg_b_nxt.prio_high = wb_dat_i[ext_irq_pkg::PH_B_HIGH]; // R10
        end

        if (wr_take && reg_hit(wb_adr_i, ext_irq_pkg::IDX_GATE)) begin
            gate_nxt = wb_dat_i[ext_irq_pkg::GATE_BIT]; // R11
        end

        if (wr_take && reg_hit(wb_adr_i, ext_irq_pkg::IDX_MASK)) begin
            mask_nxt = wb_dat_i[1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg_b_r <= ext_irq_pkg::CFG_RST;
            cfg_c_r <= ext_irq_pkg::CFG_RST;
            gate_r  <= ext_irq_pkg::GATE_RST;
            mask_r  <= ext_irq_pkg::EVT_RST;
        end else begin
            cfg_b_r <= cfg_b_nxt;
            cfg_c_r <= cfg_c_nxt;
            gate_r  <= gate_nxt;
            mask_r  <= mask_nxt;
        end
    end

    // ---------------- Request flags, core request and event status
    // The core acknowledges the source it is servicing; only that flag drops
    assign serve_b = core_ack && (core_ack_sel == ext_irq_pkg::SRC_B);
    assign serve_c = core_ack && (core_ack_sel == ext_irq_pkg::SRC_C);

    always_comb begin
        // Detection wins over a service clear in the same cycle, so a
        // new edge is never lost; a held low level keeps the flag set through service.
        flag_b_nxt = det_b | (flag_b_r & ~serve_b); // R4
        flag_c_nxt = det_c | (flag_c_r & ~serve_c); // R3

        // Status event: a flag rising
        evt = 2'h0;
        evt[ext_irq_pkg::EVT_B] = flag_b_nxt & ~flag_b_r;
        evt[ext_irq_pkg::EVT_C] = flag_c_nxt & ~flag_c_r;
        if (wr_take && reg_hit(wb_adr_i, ext_irq_pkg::IDX_STATUS)) begin
            status_nxt = w1c(status_r, wb_dat_i[1:0], evt);
        end else begin
            status_nxt = w1c(status_r, 2'h0, evt);
        end

        core_req_nxt = winner;
        // The gate masks both inputs; the power-fail source is outside this block
        if (!gate_r) begin
            core_req_nxt = ext_irq_pkg::CORE_REQ_RST; // R11
        end

        // Level interrupt from masked status
        irq_nxt = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flag_b_r   <= 1'b0;
            flag_c_r   <= 1'b0;
            status_r   <= ext_irq_pkg::EVT_RST;
            core_req_r <= ext_irq_pkg::CORE_REQ_RST;
            irq_r      <= 1'b0;
        end else begin
            flag_b_r   <= flag_b_nxt;
            flag_c_r   <= flag_c_nxt;
            status_r   <= status_nxt;
            core_req_r <= core_req_nxt;
            irq_r      <= irq_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;
    assign core_req = core_req_r;
    assign irq_o    = irq_r;

endmodule // ext_irq_pair_control

// ==== verif/ext_irq_pair_control_sva.sv ====
// Port-level checker for the external interrupt pair control
`timescale 1ns/1ns
module ext_irq_pair_control_sva #(
    parameter int ADR_W = 12
) (
    input wire logic                  sys_clk,
    input wire logic                  srst,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_we_i,
    input wire logic [ADR_W-1:0]      wb_adr_i,
    input wire logic [3:0]            wb_sel_i,
    input wire logic [31:0]           wb_dat_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    input wire logic                  ext_irq_b_pin,
    input wire logic                  ext_irq_c_pin,
    input wire logic                  core_ack,
    input wire logic                  core_ack_sel,
    input wire ext_irq_pkg::core_req_t core_req,
    input wire logic                  irq_o
);
    // Shadow copies of the writable settings, taken at the write's ack edge
    logic [7:0] ctl_r, ctl_nxt, ph_r, ph_nxt;
    logic       gate_r, gate_nxt;
    logic [1:0] mask_r, mask_nxt, lvl_b, lvl_c;
    logic       wr_hit;

    assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign lvl_b  = {ph_r[ext_irq_pkg::PH_B_HIGH], ctl_r[ext_irq_pkg::CTL_B_PRIO_LOW]};
    assign lvl_c  = {ph_r[ext_irq_pkg::PH_C_HIGH], ctl_r[ext_irq_pkg::CTL_C_PRIO_LOW]};

    always_comb begin
        ctl_nxt  = ctl_r;
        ph_nxt   = ph_r;
        gate_nxt = gate_r;
        mask_nxt = mask_r;
        if (srst) begin
            ctl_nxt  = 8'h00;
            ph_nxt   = 8'h00;
            gate_nxt = 1'b0;
            mask_nxt = 2'h0;
        end else if (wr_hit) begin
            if (wb_adr_i == ADR_W'({ext_irq_pkg::IDX_CONTROL, 2'b00})) ctl_nxt = wb_dat_i[7:0];
            if (wb_adr_i == ADR_W'({ext_irq_pkg::IDX_PRIO_HIGH, 2'b00})) ph_nxt = wb_dat_i[7:0];
            if (wb_adr_i == ADR_W'({ext_irq_pkg::IDX_GATE, 2'b00})) gate_nxt = wb_dat_i[0];
            if (wb_adr_i == ADR_W'({ext_irq_pkg::IDX_MASK, 2'b00})) mask_nxt = wb_dat_i[1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        ctl_r  <= ctl_nxt;
        ph_r   <= ph_nxt;
        gate_r <= gate_nxt;
        mask_r <= mask_nxt;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("bus request not answered in the next cycle");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_req_needs_gate: assert property (core_req.valid |-> $past(gate_r))
        else $error("request passed with the gate closed");
    a_b_needs_enable: assert property ((core_req.valid && !core_req.sel) |-> $past(ctl_r[2]))
        else $error("second input request while disabled");
    a_c_needs_enable: assert property ((core_req.valid && core_req.sel) |-> $past(ctl_r[6]))
        else $error("third input request while disabled");
    a_level_match: assert property (core_req.valid |->
        core_req.level == (core_req.sel ? $past(lvl_c) : $past(lvl_b)))
        else $error("request level differs from priority bits");
    a_irq_needs_mask: assert property (irq_o |-> mask_r != 2'h0)
        else $error("interrupt raised with all events masked");

    c_req_c: cover property (core_req.valid && core_req.sel);
    c_req_b: cover property (core_req.valid && !core_req.sel);
    c_irq: cover property (irq_o);
endmodule // ext_irq_pair_control_sva

bind ext_irq_pair_control ext_irq_pair_control_sva #(.ADR_W(ADR_W)) i_sva (
    .sys_clk(sys_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_irq_b_pin(ext_irq_b_pin),
    .ext_irq_c_pin(ext_irq_c_pin), .core_ack(core_ack), .core_ack_sel(core_ack_sel),
    .core_req(core_req), .irq_o(irq_o));

// ==== verif/irq_source_model.sv ====
// Model of the external sources that pull the two interrupt pins low
`timescale 1ns/1ns
module irq_source_model (
    input  wire logic sys_clk,
    output logic      pin_b,
    output logic      pin_c
);
    // Pins carry pull-ups, so a quiet source leaves them high
    initial begin
        pin_b = ext_irq_pkg::PIN_IDLE;
        pin_c = ext_irq_pkg::PIN_IDLE;
    end

    task automatic drive(input logic b_low, input logic c_low);
        @(posedge sys_clk);
        pin_b <= !b_low;
        pin_c <= !c_low;
    endtask
endmodule // irq_source_model

// ==== verif/ext_irq_pair_control_tb.sv ====
// Self-checking bench for the external interrupt pair control
`timescale 1ns/1ns
module ext_irq_pair_control_tb;
    localparam int ADR_W = 12;
    logic                   sys_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [ADR_W-1:0]       wb_adr_i;
    logic [3:0]             wb_sel_i;
    logic [31:0]            wb_dat_i, wb_dat_o;
    logic                   pin_b, pin_c, core_ack, core_ack_sel, irq_o;
    ext_irq_pkg::core_req_t core_req;
    int                     bad_count, comparisons;
    logic [7:0]             exp_q[$];
    logic [7:0]             r;
    logic [1:0]             lb, lc;
    logic [7:0]             idx_tab [7] = '{ext_irq_pkg::IDX_CONTROL, ext_irq_pkg::IDX_PRIO_HIGH,
        ext_irq_pkg::IDX_GATE, ext_irq_pkg::IDX_STATUS, ext_irq_pkg::IDX_MASK,
        ext_irq_pkg::IDX_CORE_STATE, 8'hFC};

    always #5 sys_clk = ~sys_clk;

    ext_irq_pair_control #(.ADR_W(ADR_W)) i_dut (.sys_clk(sys_clk), .srst(srst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ext_irq_b_pin(pin_b), .ext_irq_c_pin(pin_c), .core_ack(core_ack),
        .core_ack_sel(core_ack_sel), .core_req(core_req), .irq_o(irq_o));
    irq_source_model i_src (.sys_clk(sys_clk), .pin_b(pin_b), .pin_c(pin_c));

    task automatic wrap_up;
        if (exp_q.size() != 0) bad_count++;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check_rd(input logic [31:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== {24'h0, exp}) begin
            bad_count++;
            $display("ERROR %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_port(input ext_irq_pkg::core_req_t exp_req, input logic exp_irq);
        #1;
        comparisons++;
        if (core_req !== exp_req || irq_o !== exp_irq) begin
            bad_count++;
            $display("ERROR %0t: core_req %h irq %b", $time, core_req, irq_o);
        end
    endtask

    // One classic cycle; the wait is bounded so a silent slave ends the run
    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= ADR_W'({idx, 2'b00});
        wb_dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (n >= 16) begin
            bad_count++;
            $display("ERROR %0t: no ack", $time);
            wrap_up();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, idx, 8'h00);
    endtask

    task automatic service(input logic sel);
        @(posedge sys_clk);
        core_ack     <= 1'b1;
        core_ack_sel <= sel;
        @(posedge sys_clk);
        core_ack     <= 1'b0;
    endtask

    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("ERROR %0t: unexpected read", $time);
            end else check_rd(wb_dat_o, exp_q.pop_front());
        end
    end

    initial begin
        sys_clk = 0; srst = 1; wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0; wb_adr_i = '0;
        wb_dat_i = '0; wb_sel_i = 4'hF; core_ack = 0; core_ack_sel = 0;
        bad_count = 0; comparisons = 0;
        void'($urandom(10));
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        foreach (idx_tab[i]) rd(idx_tab[i], 8'h00);
        bus(1'b1, 8'hFC, 8'hFF);
        rd(8'hFC, 8'h00);
        wb_sel_i <= 4'hE;
        bus(1'b1, ext_irq_pkg::IDX_GATE, 8'h01);
        wb_sel_i <= 4'hF;
        rd(ext_irq_pkg::IDX_GATE, 8'h00);
        r = 8'($urandom);
        bus(1'b1, ext_irq_pkg::IDX_CONTROL, r);
        rd(ext_irq_pkg::IDX_CONTROL, r & 8'hDD);
        r = 8'($urandom);
        bus(1'b1, ext_irq_pkg::IDX_PRIO_HIGH, r);
        rd(ext_irq_pkg::IDX_PRIO_HIGH, r & 8'h88);
        bus(1'b1, ext_irq_pkg::IDX_PRIO_HIGH, 8'h00);
        // Level mode on the second input, gate closed first
        bus(1'b1, ext_irq_pkg::IDX_CONTROL, 8'h04);
        bus(1'b1, ext_irq_pkg::IDX_MASK, 8'h03);
        i_src.drive(1'b1, 1'b0);
        repeat (8) @(posedge sys_clk);
        rd(ext_irq_pkg::IDX_CONTROL, 8'h06);
        check_port(ext_irq_pkg::CORE_REQ_RST, 1'b1);
        bus(1'b1, ext_irq_pkg::IDX_GATE, 8'h01);
        repeat (3) @(posedge sys_clk);
        check_port(ext_irq_pkg::core_req_t'{1'b1, ext_irq_pkg::SRC_B, 2'h0}, 1'b1);
        i_src.drive(1'b0, 1'b0);
        repeat (6) @(posedge sys_clk);
        service(ext_irq_pkg::SRC_B);
        repeat (3) @(posedge sys_clk);
        rd(ext_irq_pkg::IDX_CONTROL, 8'h04);
        rd(ext_irq_pkg::IDX_STATUS, 8'h01);
        bus(1'b1, ext_irq_pkg::IDX_STATUS, 8'h01);
        repeat (2) @(posedge sys_clk);
        check_port(ext_irq_pkg::CORE_REQ_RST, 1'b0);
        // Edge mode on the third input; a low held after service must not re-set
        bus(1'b1, ext_irq_pkg::IDX_CONTROL, 8'h10);
        i_src.drive(1'b0, 1'b1);
        repeat (8) @(posedge sys_clk);
        rd(ext_irq_pkg::IDX_CONTROL, 8'h30);
        rd(ext_irq_pkg::IDX_CORE_STATE, 8'h00);
        bus(1'b1, ext_irq_pkg::IDX_CONTROL, 8'h50);
        repeat (3) @(posedge sys_clk);
        rd(ext_irq_pkg::IDX_CORE_STATE, 8'h03);
        service(ext_irq_pkg::SRC_C);
        repeat (3) @(posedge sys_clk);
        rd(ext_irq_pkg::IDX_CONTROL, 8'h50);
        i_src.drive(1'b0, 1'b0);
        bus(1'b1, ext_irq_pkg::IDX_STATUS, 8'h03);
        // Both inputs pending at random levels
        repeat (6) begin
            lb = 2'($urandom);
            lc = 2'($urandom);
            bus(1'b1, ext_irq_pkg::IDX_CONTROL, {lc[0], 3'b101, lb[0], 3'b101});
            bus(1'b1, ext_irq_pkg::IDX_PRIO_HIGH, {lc[1], 3'b000, lb[1], 3'b000});
            i_src.drive(1'b1, 1'b1);
            repeat (2) @(posedge sys_clk);
            i_src.drive(1'b0, 1'b0);
            repeat (8) @(posedge sys_clk);
            if (lc > lb) begin
                rd(ext_irq_pkg::IDX_CORE_STATE, {4'h0, lc, 2'b11});
                service(ext_irq_pkg::SRC_C);
                repeat (3) @(posedge sys_clk);
                rd(ext_irq_pkg::IDX_CORE_STATE, {4'h0, lb, 2'b01});
                service(ext_irq_pkg::SRC_B);
            end else begin
                rd(ext_irq_pkg::IDX_CORE_STATE, {4'h0, lb, 2'b01});
                service(ext_irq_pkg::SRC_B);
                repeat (3) @(posedge sys_clk);
                rd(ext_irq_pkg::IDX_CORE_STATE, {4'h0, lc, 2'b11});
                service(ext_irq_pkg::SRC_C);
            end
            repeat (3) @(posedge sys_clk);
            rd(ext_irq_pkg::IDX_CORE_STATE, 8'h00);
            bus(1'b1, ext_irq_pkg::IDX_STATUS, 8'h03);
        end
        repeat (2) @(posedge sys_clk);
        check_port(ext_irq_pkg::CORE_REQ_RST, 1'b0);
        wrap_up();
    end
endmodule // ext_irq_pair_control_tb
